// [mmi_buf2.sv]
// two-entry valid/ready buffer
`timescale 1ns/1ps
module mmi_buf2 #(
  parameter int W = 6,
  parameter int DEPTH = 2
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  logic [W-1:0] mem [DEPTH];
  logic [1:0] cnt_q;
  logic rd_q;
  logic wr_q;
  logic push;
  logic pop;
  assign o_ready = (cnt_q != 2'(DEPTH));
  assign o_valid = (cnt_q != 2'h0);
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_data = mem[rd_q];
  // storage written on push; reset not needed for data
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wr_q] <= i_data;
    end
  end
  // pointers and fill count
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cnt_q <= 2'h0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + 2'(push) - 2'(pop);
    end
  end
endmodule

// [mmi_mac_if.sv]
// mii/rmii mac-facing logic of the transceiver
`timescale 1ns/1ps
`include "mmi_map.svh"
module mmi_mac_if (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_interface_select_strap,
  input wire logic i_autoneg_en,
  input wire logic i_an_speed100,
  input wire logic i_an_full_duplex,
  input wire logic i_force_speed100,
  input wire logic i_force_full_duplex,
  input wire logic i_pair_swap_disable,
  input wire logic i_crossover_seen,
  input wire logic i_ref_clk,
  input wire logic [3:0] i_txd,
  input wire logic i_tx_en,
  input wire logic i_tx_er,
  output logic [3:0] o_line_txd,
  output logic o_line_tx_en,
  output logic o_line_tx_er,
  input wire logic i_line_carrier,
  input wire logic i_line_valid,
  input wire logic [3:0] i_line_rxd,
  input wire logic i_line_err,
  output logic o_line_ready,
  output logic o_txclk,
  output logic o_rxclk,
  output logic [3:0] o_rxd,
  output logic o_rx_dv,
  output logic o_rx_er,
  output logic o_crs,
  output logic o_col_crs_dv,
  output logic o_rmii_mode,
  output logic o_speed100,
  output logic o_full_duplex,
  output logic o_pair_swap
);
  logic rmii_q;
  logic strap_seen_q;
  logic speed100;
  logic fdx;
  logic ref_s;
  logic ref_prev_q;
  logic ref_rise;
  logic [3:0] hold_q;
  logic dibit_tick;
  logic [3:0] div_q;
  logic mii_clk_q;
  logic mii_tick;
  logic phase_q;
  logic [3:0] cur_q;
  logic cur_er_q;
  logic [3:0] txn_q;
  logic buf_valid;
  logic [4:0] buf_data;
  logic buf_pop;
  logic carrier_s;
  logic tx_act;
  mmi_pkg::mmi_rx_e st_q;

  // strap caught once after reset release, then frozen
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rmii_q <= 1'b0;
      strap_seen_q <= 1'b0;
    end else if (!strap_seen_q) begin
      rmii_q <= i_interface_select_strap; // [R7]
      strap_seen_q <= 1'b1;
    end
  end
  assign o_rmii_mode = rmii_q;

  // forced bits only matter with autoneg off
  assign speed100 = i_autoneg_en ? i_an_speed100 : i_force_speed100; // [R1]
  assign fdx = i_autoneg_en ? i_an_full_duplex : i_force_full_duplex; // [R1]
  assign o_speed100 = speed100;
  assign o_full_duplex = fdx;

  // swap follows cable unless disabled
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_pair_swap <= 1'b0;
    end else if (!i_pair_swap_disable) begin
      o_pair_swap <= i_crossover_seen; // [R6]
    end else begin
      o_pair_swap <= 1'b0; // [R6]
    end
  end

  // reference clock and carrier are foreign; synchronise both
  mmi_sync #(.W(2)) u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async({i_ref_clk, i_line_carrier}),
    .o_sync({ref_s, carrier_s})
  );

  // edge of reference clock; limited by sampling, bench runs it slow
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ref_prev_q <= 1'b0;
    end else begin
      ref_prev_q <= ref_s; // [R18]
    end
  end
  assign ref_rise = ref_s && !ref_prev_q; // [R12]

  // at 10 mb/s each di-bit holds for ten reference edges
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      hold_q <= 4'h0;
    end else if (ref_rise) begin
      if (speed100 || hold_q == 4'(`MMI_DIBIT_HOLD_10 - 1)) begin
        hold_q <= 4'h0; // [R24]
      end else begin
        hold_q <= hold_q + 4'h1;
      end
    end
  end
  assign dibit_tick = ref_rise && (speed100 || hold_q == 4'h0);

  // mii clock: 25 mhz is our own clock, 2.5 mhz by divider
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      div_q <= 4'h0;
      mii_clk_q <= 1'b0;
    end else if (div_q == 4'(`MMI_HALF_10 - 1)) begin
      div_q <= 4'h0;
      mii_clk_q <= ~mii_clk_q; // [R23]
    end else begin
      div_q <= div_q + 4'h1;
    end
  end
  // at 100 mb/s the nibble moves every cycle; clock out is inverted mclk
  assign mii_tick = speed100 ? 1'b1 :
                    (div_q == 4'(`MMI_HALF_10 - 1)) && mii_clk_q;
  assign o_txclk = rmii_q ? 1'b0 :
                   (speed100 ? ~i_mclk : mii_clk_q); // [R8] [R25] [R20]
  assign o_rxclk = o_txclk; // [R10]

  // transmit: capture nibble or di-bit straight to line, no buffer
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_line_txd <= 4'h0;
      o_line_tx_en <= 1'b0;
      o_line_tx_er <= 1'b0;
      txn_q <= 4'h0;
    end else if (rmii_q) begin
      if (dibit_tick) begin
        // upper data pins are tied low by the board and ignored
        txn_q <= {i_txd[1:0], txn_q[3:2]}; // [R19] [R21]
        o_line_tx_en <= i_tx_en;
        o_line_tx_er <= 1'b0;
        if (phase_q) begin
          o_line_txd <= {i_txd[1:0], txn_q[3:2]};
        end
      end
    end else if (mii_tick) begin
      o_line_txd <= i_txd; // [R8]
      o_line_tx_en <= i_tx_en; // [R9]
      o_line_tx_er <= i_tx_en && i_tx_er; // [R9]
    end
  end
  assign tx_act = o_line_tx_en;

  // elasticity buffer between recovered line data and local timing
  mmi_buf2 #(.W(5), .DEPTH(2)) u_buf (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_valid(i_line_valid),
    .o_ready(o_line_ready),
    .i_data({i_line_err, i_line_rxd}),
    .o_valid(buf_valid),
    .i_ready(buf_pop),
    .o_data(buf_data)
  ); // [R19]

  // a nibble is taken at start of each nibble time
  assign buf_pop = rmii_q ? (dibit_tick && !phase_q) : mii_tick;

  // receive sequencer: idle, preamble zeros, data, drain after carrier
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_q <= mmi_pkg::MMI_RX_IDLE;
      phase_q <= 1'b0;
      cur_q <= 4'h0;
      cur_er_q <= 1'b0;
    end else begin
      if (dibit_tick) begin
        phase_q <= ~phase_q;
      end
      if (buf_pop) begin
        cur_q <= buf_valid ? buf_data[3:0] : 4'h0; // [R17]
        cur_er_q <= buf_valid && buf_data[4];
      end
      case (st_q)
        mmi_pkg::MMI_RX_IDLE: begin
          if (carrier_s) begin
            st_q <= mmi_pkg::MMI_RX_PRE;
          end
        end
        mmi_pkg::MMI_RX_PRE: begin
          if (buf_pop && buf_valid) begin
            st_q <= mmi_pkg::MMI_RX_DATA;
          end else if (!carrier_s && buf_pop) begin
            st_q <= mmi_pkg::MMI_RX_IDLE; // [R16]
          end
        end
        mmi_pkg::MMI_RX_DATA: begin
          if (!carrier_s && buf_pop) begin
            st_q <= buf_valid ? mmi_pkg::MMI_RX_DRAIN :
                                mmi_pkg::MMI_RX_IDLE;
          end
        end
        mmi_pkg::MMI_RX_DRAIN: begin
          if (buf_pop && !buf_valid) begin
            st_q <= mmi_pkg::MMI_RX_IDLE;
          end
        end
        default: begin
          st_q <= mmi_pkg::MMI_RX_IDLE;
        end
      endcase
    end
  end

  // mii data and rmii di-bit outputs, registered
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rxd <= 4'h0;
      o_rx_dv <= 1'b0;
      o_rx_er <= 1'b0;
    end else if (rmii_q) begin
      // rmii di-bit: low half first, then high half; phase_q is set
      // by the pop tick, so high phase means the first di-bit is shown
      o_rxd <= {2'b00, phase_q ? cur_q[1:0] : cur_q[3:2]}; // [R12]
      o_rx_dv <= 1'b0; // [R20]
      o_rx_er <= (st_q != mmi_pkg::MMI_RX_IDLE) && cur_er_q; // [R22]
    end else if (mii_tick) begin
      o_rxd <= cur_q; // [R10]
      o_rx_dv <= (st_q == mmi_pkg::MMI_RX_DATA) ||
                 (st_q == mmi_pkg::MMI_RX_DRAIN); // [R10]
      o_rx_er <= (st_q != mmi_pkg::MMI_RX_IDLE) && cur_er_q; // [R11]
    end
  end

  // carrier sense per duplex mode
  assign o_crs = rmii_q ? 1'b0 :
                 (fdx ? carrier_s : (carrier_s || tx_act)); // [R2] [R4]

  // collision pin or crs_dv; carrier rise shown without waiting a tick
  always_comb begin
    if (rmii_q) begin
      case (st_q)
        mmi_pkg::MMI_RX_IDLE: o_col_crs_dv = carrier_s; // [R13]
        mmi_pkg::MMI_RX_PRE: o_col_crs_dv = 1'b1; // [R16]
        mmi_pkg::MMI_RX_DATA: o_col_crs_dv = 1'b1; // [R14]
        // low on the first di-bit, high on the second
        mmi_pkg::MMI_RX_DRAIN: o_col_crs_dv = !phase_q; // [R15]
        default: o_col_crs_dv = `MMI_RST_CRSDV;
      endcase
    end else begin
      o_col_crs_dv = !fdx && tx_act && carrier_s; // [R3] [R5]
    end
  end
endmodule

// [mmi_mac_if_assertions.sv]
// concurrent checks on the mii/rmii mac interface ports
`timescale 1ns/1ps
module mmi_mac_if_assertions (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_interface_select_strap,
  input wire logic i_autoneg_en,
  input wire logic i_an_speed100,
  input wire logic i_an_full_duplex,
  input wire logic i_force_speed100,
  input wire logic i_force_full_duplex,
  input wire logic i_pair_swap_disable,
  input wire logic i_line_carrier,
  input wire logic i_tx_en,
  input wire logic o_line_tx_en,
  input wire logic o_txclk,
  input wire logic o_rxclk,
  input wire logic [3:0] o_rxd,
  input wire logic o_rx_dv,
  input wire logic o_rx_er,
  input wire logic o_crs,
  input wire logic o_col_crs_dv,
  input wire logic o_rmii_mode,
  input wire logic o_speed100,
  input wire logic o_full_duplex,
  input wire logic o_pair_swap
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // mii half duplex, where carrier and collision are live
  logic mii_hd;
  assign mii_hd = !o_rmii_mode && !o_full_duplex;
  speed_sel_a: assert property (
    o_speed100 == (i_autoneg_en ? i_an_speed100 : i_force_speed100))
    else $error("speed select wrong");
  duplex_sel_a: assert property (
    o_full_duplex == (i_autoneg_en ? i_an_full_duplex : i_force_full_duplex))
    else $error("duplex select wrong");
  hd_crs_a: assert property (
    mii_hd && i_tx_en && o_line_tx_en |-> o_crs)
    else $error("no carrier sense while sending");
  col_crs_a: assert property (
    mii_hd && o_col_crs_dv |-> o_crs) else $error("collision without crs");
  fd_crs_a: assert property (
    (!o_rmii_mode && o_full_duplex && !i_line_carrier)[*5] |-> !o_crs)
    else $error("full duplex crs without receive");
  fd_nocol_a: assert property (
    !o_rmii_mode && o_full_duplex |-> !o_col_crs_dv)
    else $error("collision in full duplex");
  swap_off_a: assert property (
    i_pair_swap_disable[*2] |-> !o_pair_swap) else $error("swap while off");
  strap_mode_a: assert property (
    $fell(i_rst) |=> o_rmii_mode == $past(i_interface_select_strap))
    else $error("mode differs from strap");
  crsdv_rise_a: assert property (
    o_rmii_mode && $rose(i_line_carrier) |->
    ##[1:4] (o_col_crs_dv && o_rxd[1:0] == 2'b00))
    else $error("crs_dv late or data not 00");
  rmii_quiet_a: assert property (
    o_rmii_mode |-> !o_txclk && !o_rxclk && !o_rx_dv && !o_crs)
    else $error("mii-only pin active in rmii");
  txclk_half_a: assert property (
    !o_rmii_mode && !o_speed100 && $rose(o_txclk) |-> o_txclk[*5] ##1 !o_txclk)
    else $error("slow transmit clock half period wrong");
  cover property (mii_hd && o_col_crs_dv);
  cover property (o_rmii_mode && $fell(o_col_crs_dv));
  cover property (o_rx_er);
endmodule
bind mmi_mac_if mmi_mac_if_assertions u_chk (.*);

// [mmi_mac_if_bench.sv]
// self-checking bench for the mii/rmii mac interface
`timescale 1ns/1ps
module mmi_mac_if_bench;
  logic i_mclk = 0, i_rst = 1, i_interface_select_strap = 0;
  logic i_autoneg_en = 0, i_an_speed100 = 0, i_an_full_duplex = 0;
  logic i_force_speed100 = 0, i_force_full_duplex = 0;
  logic i_pair_swap_disable = 0, i_crossover_seen = 0, i_ref_clk = 0;
  logic i_line_carrier = 0, i_line_valid = 0, i_line_err = 0, send = 0;
  logic [3:0] i_txd, o_line_txd, i_line_rxd = 4'h0, o_rxd, nib = 4'h0;
  logic [3:0] rx_last, exp_rx = 4'h0;
  logic i_tx_en, i_tx_er, o_line_tx_en, o_line_tx_er, o_line_ready;
  logic o_txclk, o_rxclk, o_rx_dv, o_rx_er, o_crs, o_col_crs_dv;
  logic o_rmii_mode, o_speed100, o_full_duplex, o_pair_swap;
  logic [5:0] obs;
  int err_total = 0;
  int tests_run = 0;
  mmi_mac_if DUT (.*);
  mmi_mac_model u_mac (.i_txclk(o_txclk), .i_rxclk(o_rxclk), .i_send(send),
    .i_nib(nib), .i_rxd(o_rxd), .i_rx_dv(o_rx_dv), .o_txd(i_txd),
    .o_tx_en(i_tx_en), .o_tx_er(i_tx_er), .o_rx_last(rx_last));
  // flags the bounded waits poll, one bit each
  assign obs = {rx_last === exp_rx, o_line_ready, o_crs, o_rx_er,
    o_col_crs_dv, o_line_tx_en};
  initial begin
    forever #20 i_mclk = ~i_mclk;
  end
  // reference clock free-running, phase unrelated to the own clock
  initial begin
    #7;
    forever #160 i_ref_clk = ~i_ref_clk;
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded poll at falling edges; a run-out ends the run
  task automatic wait_for(input int k, input logic val);
    int n;
    n = 0;
    while (obs[k] !== val && n < 400) begin
      @(negedge i_mclk);
      n++;
    end
    chk(8'(obs[k]), 8'(val));
    if (obs[k] !== val) summarize();
  endtask
  task automatic restart(input logic rmii);
    @(negedge i_mclk);
    i_rst = 1;
    i_interface_select_strap = rmii;
    repeat (6) @(negedge i_mclk);
    i_rst = 0;
    repeat (2) @(negedge i_mclk);
    chk(8'(o_rmii_mode), 8'(rmii));
  endtask
  // valid held until the edge that sees ready high
  task automatic push(input logic [3:0] d, input logic e);
    i_line_rxd = d;
    i_line_err = e;
    i_line_valid = 1;
    wait_for(4, 1);
    @(negedge i_mclk);
    i_line_valid = 0;
    @(negedge i_mclk);
  endtask
  initial begin
    restart(1);
    for (int i = 0; i < 8; i++) begin
      {i_autoneg_en, i_an_speed100, i_force_speed100} = i[2:0];
      i_an_full_duplex = i[0];
      i_force_full_duplex = i[1];
      @(negedge i_mclk);
      chk(8'({o_speed100, o_full_duplex}),
        i[2] ? 8'({i[1], i[0]}) : 8'({i[0], i[1]}));
    end
    i_crossover_seen = 1;
    repeat (3) @(negedge i_mclk);
    chk(8'(o_pair_swap), 8'h01);
    i_pair_swap_disable = 1;
    repeat (3) @(negedge i_mclk);
    chk(8'(o_pair_swap), 8'h00);
    $display("config test done");
    i_line_carrier = 1;
    wait_for(1, 1);
    chk(8'(o_rxd[1:0]), 8'h00);
    push(4'h6, 1);
    wait_for(2, 1);
    push(4'h9, 0);
    push(4'h3, 0);
    push(4'hc, 0);
    i_line_carrier = 0;
    wait_for(1, 0);
    wait_for(1, 1);
    wait_for(1, 0);
    $display("rmii receive test done");
    send = 1;
    nib = 4'ha;
    restart(0);
    wait_for(0, 1);
    chk(8'(o_line_txd), 8'h0a);
    chk(8'({o_crs, o_col_crs_dv}), 8'h00);
    i_line_carrier = 1;
    wait_for(3, 1);
    chk(8'(o_col_crs_dv), 8'h00);
    exp_rx = 4'h5;
    push(4'h5, 0);
    wait_for(5, 1);
    $display("mii full duplex test done");
    i_line_carrier = 0;
    {i_autoneg_en, i_force_speed100, i_force_full_duplex} = 3'h0;
    restart(0);
    wait_for(0, 1);
    chk(8'(o_crs), 8'h01);
    i_line_carrier = 1;
    wait_for(1, 1);
    exp_rx = 4'hc;
    push(4'hc, 0);
    wait_for(5, 1);
    $display("mii half duplex test done");
    summarize();
  end
endmodule

// [mmi_mac_model.sv]
// mac-side model: sends nibbles on txclk rise, captures rx nibbles
`timescale 1ns/1ps
module mmi_mac_model (
  input wire logic i_txclk,
  input wire logic i_rxclk,
  input wire logic i_send,
  input wire logic [3:0] i_nib,
  input wire logic [3:0] i_rxd,
  input wire logic i_rx_dv,
  output logic [3:0] o_txd,
  output logic o_tx_en,
  output logic o_tx_er,
  output logic [3:0] o_rx_last
);
  initial begin
    o_txd = 4'h0;
    o_tx_en = 1'b0;
    o_tx_er = 1'b0;
  end
  // idle data flips each clock so a stale value never looks valid
  always @(posedge i_txclk) begin
    o_tx_en <= i_send;
    o_txd <= i_send ? i_nib : ~o_txd;
  end
  // capture only while data valid is high
  always @(posedge i_rxclk) begin
    if (i_rx_dv === 1'b1) begin
      o_rx_last <= i_rxd;
    end
  end
endmodule

// [mmi_map.svh]
// constants for the mac interface block of the phy
// Functional notes
// R1: with autoneg off, forced speed and duplex bits apply; ignored otherwise.
// R2: half duplex carrier sense covers transmit or receive activity.
// R3: half duplex collision when receiving while transmitting.
// R4: full duplex transmits and receives together; carrier sense is receive only.
// R5: full duplex never raises the collision indication.
// R6: pair swap follows cabling unless the swap disable control is set.
// R7: mii or rmii chosen by the interface select strap level.
// R8: mii mode drives transmit clock; mac sends 4-bit nibble on its rise.
// R9: mac holds tx enable during valid nibbles and flags errors on tx error.
// R10: mii mode drives receive nibble and clock; mac samples while data valid.
// R11: receive error is driven high on a detected receive data error.
// R12: rmii uses one shared reference clock with 2-bit paths both ways.
// R13: crs_dv rises as soon as carrier is detected.
// R14: on carrier loss crs_dv falls only on a first di-bit.
// R15: with bits left after carrier, crs_dv high on second, low on first di-bit.
// R16: during false carrier crs_dv stays high for the whole activity.
// R17: after crs_dv rises, receive di-bit is 00 until decoded data is ready.
// R18: reference clock runs continuously; all rmii signals timed to it.
// R19: rmii transmit is unbuffered; receive passes an elasticity buffer.
// R20: rmii shows crs_dv on the collision pin; mii-only pins unused.
// R21: board ties upper two transmit data inputs low in rmii mode.
// R22: rmii mode always drives receive error; mac may ignore it.
// R23: 10 mb/s mii nibbles valid on rising edge of 2.5 mhz receive clock.
// R24: rmii reference clock is 50 mhz; 10 mb/s di-bit held ten cycles.
// R25: 100 mb/s mii runs 25 mhz clocks, one nibble per clock.
`ifndef MMI_MAP_SVH
`define MMI_MAP_SVH
`define MMI_CLK_MHZ 25
`define MMI_TXCLK_10_NS 400
// 10 mb/s mii clock half period in own clock cycles
`define MMI_HALF_10 ((`MMI_TXCLK_10_NS * `MMI_CLK_MHZ) / 2000)
`define MMI_DIBIT_HOLD_10 10
`define MMI_RST_CRSDV 1'b0
`endif

// [mmi_pkg.sv]
// types for the mac interface block
package mmi_pkg;
  typedef enum logic [1:0] {
    MMI_RX_IDLE = 2'b00,
    MMI_RX_PRE = 2'b01,
    MMI_RX_DATA = 2'b10,
    MMI_RX_DRAIN = 2'b11
  } mmi_rx_e;
endpackage

// [mmi_sync.sv]
// three-stage synchroniser with agreement of last two stages
`timescale 1ns/1ps
module mmi_sync #(
  parameter int W = 1
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  // first stage feeds only the second
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // a bit changes only once stages two and three agree
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_sync <= '0;
    end else begin
      for (int k = 0; k < W; k++) begin
        if (s2_q[k] == s3_q[k]) begin
          o_sync[k] <= s3_q[k];
        end
      end
    end
  end
endmodule
